// file: rtl/fsr_host.sv
// flash host end: frame engine, power-up waits, reset sequence
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module fsr_host #(
  parameter int VSL_CYC = fsr_pkg::VSL_CYC,
  parameter int PUW_CYC = fsr_pkg::PUW_CYC,
  parameter int RST_CYC = fsr_pkg::RST_CYC,
  parameter int SCK_HALF = fsr_pkg::SCK_HALF
) (
  input wire logic clk_i, // clock
  input wire logic nrst_i, // sync reset, active low
  input wire logic [3:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after rd_i
  fsr_link_if.host link // serial link
);
  typedef enum {F_IDLE, F_SHIFT, F_GAP} fsr_fst_t;
  typedef enum {H_IDLE, H_CMD, H_STAT, H_ARM, H_RST, H_WAIT} fsr_hst_t;
  fsr_fst_t fst_r;
  fsr_hst_t hst_r;
  logic started_r;
  logic sel_ok_r;
  logic ta_busy;
  logic tb_busy;
  logic ta_start;
  logic [fsr_pkg::TMR_W-1:0] ta_load;
  logic cs_r;
  logic sck_r;
  logic fq_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [7:0] ph_r;
  logic [4:0] left_r;
  logic [4:0] nrd_r;
  logic f_go;
  logic f_rd;
  logic [7:0] f_op;
  logic f_done;
  logic quad_r;
  logic safe_r;
  logic refused_r;
  logic [7:0] last_r;
  logic [7:0] op_r;
  logic [7:0] rdata_r;
  logic is_wr;
  logic cmd_ok;
  logic rst_ok;
  logic veto;

  // =====================================================
  // power-up waits; timer a is reused for reset recovery
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      started_r <= 1'b0;
      sel_ok_r <= 1'b0;
    end else begin
      started_r <= 1'b1;
      if (started_r && !ta_busy) begin
        sel_ok_r <= 1'b1;
      end
    end
  end

  assign ta_start = !started_r || (hst_r == H_RST && f_done);
  assign ta_load = started_r ? fsr_pkg::TMR_W'(RST_CYC)
                             : fsr_pkg::TMR_W'(VSL_CYC);

  fsr_timer #(.W(fsr_pkg::TMR_W)) u_tmr_a (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(ta_start),
    .load_i(ta_load),
    .busy_o(ta_busy)
  );

  fsr_timer #(.W(fsr_pkg::TMR_W)) u_tmr_b (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(!started_r),
    .load_i(fsr_pkg::TMR_W'(PUW_CYC)),
    .busy_o(tb_busy)
  );

  // =====================================================
  // command sequencing
  assign is_wr = (wdata_i == fsr_pkg::OP_WREN)
                 || (wdata_i == fsr_pkg::OP_WRSR)
                 || (wdata_i == fsr_pkg::OP_PROG)
                 || (wdata_i == fsr_pkg::OP_SERASE);
  assign cmd_ok = wr_i && addr_i == fsr_pkg::HR_CMD && hst_r == H_IDLE
                  && sel_ok_r && !(is_wr && tb_busy);
  assign rst_ok = wr_i && addr_i == fsr_pkg::HR_RESET
                  && hst_r == H_IDLE && sel_ok_r;
  assign veto = hst_r == H_STAT && f_done && safe_r
                && (rx_r[fsr_pkg::ST_BUSY] || rx_r[fsr_pkg::ST_SUS]);

  always_comb begin
    f_go = 1'b0;
    f_rd = 1'b0;
    f_op = 8'h00;
    case (hst_r)
      H_IDLE: begin
        if (cmd_ok) begin
          f_go = 1'b1;
          f_op = wdata_i;
          f_rd = (wdata_i == fsr_pkg::OP_RDSR);
        end else if (rst_ok) begin
          f_go = 1'b1;
          f_op = fsr_pkg::OP_RDSR;
          f_rd = 1'b1;
        end
      end
      H_STAT: begin
        f_go = f_done && !veto;
        f_op = fsr_pkg::OP_ARM;
      end
      H_ARM: begin
        f_go = f_done;
        f_op = fsr_pkg::OP_RST;
      end
      default: begin
        f_go = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      hst_r <= H_IDLE;
    end else begin
      case (hst_r)
        H_IDLE: begin
          if (cmd_ok) begin
            hst_r <= H_CMD;
          end else if (rst_ok) begin
            hst_r <= H_STAT;
          end
        end
        H_CMD: if (f_done) hst_r <= H_IDLE;
        H_STAT: if (f_done) hst_r <= veto ? H_IDLE : H_ARM;
        H_ARM: if (f_done) hst_r <= H_RST;
        H_RST: if (f_done) hst_r <= H_WAIT;
        H_WAIT: if (!ta_busy) hst_r <= H_IDLE;
        default: hst_r <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      safe_r <= 1'b0;
      op_r <= 8'h00;
      last_r <= 8'h00;
      quad_r <= 1'b0;
    end else begin
      if (rst_ok) begin
        safe_r <= wdata_i[0];
      end
      if (f_go) begin
        op_r <= f_op;
      end
      if (f_done && op_r == fsr_pkg::OP_RDSR) begin
        last_r <= rx_r;
      end
      if (f_done && op_r == fsr_pkg::OP_QEN) begin
        quad_r <= 1'b1;
      end else if (f_done && (op_r == fsr_pkg::OP_QEX
                              || op_r == fsr_pkg::OP_RST)) begin
        quad_r <= 1'b0;
      end
    end
  end

  // a refusal in the clearing cycle is kept
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      refused_r <= 1'b0;
    end else if ((wr_i && addr_i == fsr_pkg::HR_CMD && !cmd_ok)
                 || (wr_i && addr_i == fsr_pkg::HR_RESET && !rst_ok)
                 || veto) begin
      refused_r <= 1'b1;
    end else if (wr_i && addr_i == fsr_pkg::HR_STATUS
                 && wdata_i[fsr_pkg::HS_REFUSED]) begin
      refused_r <= 1'b0;
    end
  end

  // =====================================================
  // frame engine: one opcode per select, optional read byte
  assign f_done = (fst_r == F_GAP)
                  && (ph_r == 8'(fsr_pkg::CSH_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      fst_r <= F_IDLE;
      cs_r <= 1'b1;
      sck_r <= 1'b0;
      fq_r <= 1'b0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      ph_r <= 8'h00;
      left_r <= 5'h00;
      nrd_r <= 5'h00;
    end else if (f_go && (fst_r == F_IDLE || f_done)) begin
      fst_r <= F_SHIFT;
      cs_r <= 1'b0;
      sck_r <= 1'b0;
      fq_r <= quad_r;
      tx_r <= f_op;
      rx_r <= 8'h00;
      ph_r <= 8'h00;
      left_r <= quad_r ? (f_rd ? 5'd4 : 5'd2) : (f_rd ? 5'd16 : 5'd8);
      nrd_r <= f_rd ? (quad_r ? 5'd2 : 5'd8) : 5'd0;
    end else begin
      case (fst_r)
        F_SHIFT: begin
          if (ph_r == 8'(SCK_HALF - 1)) begin
            ph_r <= 8'h00;
            sck_r <= ~sck_r;
            if (sck_r) begin
              // sample just before the fall, long after the device drove
              if (left_r <= nrd_r) begin
                rx_r <= fq_r ? {rx_r[3:0], link.io}
                             : {rx_r[6:0], link.io[1]};
              end
              tx_r <= fq_r ? {tx_r[3:0], 4'h0} : {tx_r[6:0], 1'b0};
              left_r <= left_r - 5'd1;
              if (left_r == 5'd1) begin
                fst_r <= F_GAP;
                cs_r <= 1'b1;
              end
            end
          end else begin
            ph_r <= ph_r + 8'd1;
          end
        end
        F_GAP: begin
          if (f_done) begin
            fst_r <= F_IDLE;
            ph_r <= 8'h00;
          end else begin
            ph_r <= ph_r + 8'd1;
          end
        end
        default: fst_r <= F_IDLE;
      endcase
    end
  end

  assign link.cs_n = cs_r;
  assign link.sck = sck_r;
  assign link.h_do = fq_r ? tx_r[7:4] : {3'b000, tx_r[7]};
  assign link.h_oe = (fst_r == F_SHIFT && left_r > nrd_r)
                     ? (fq_r ? 4'hf : 4'h1) : 4'h0;

  // =====================================================
  // register read port
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_r <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        fsr_pkg::HR_STATUS: begin
          rdata_r <= 8'h00;
          rdata_r[fsr_pkg::HS_BUSY] <= (hst_r != H_IDLE);
          rdata_r[fsr_pkg::HS_SEL_OK] <= sel_ok_r;
          rdata_r[fsr_pkg::HS_WR_OK] <= started_r && !tb_busy;
          rdata_r[fsr_pkg::HS_REFUSED] <= refused_r;
          rdata_r[fsr_pkg::HS_QUAD] <= quad_r;
        end
        fsr_pkg::HR_LAST: rdata_r <= last_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign rdata_o = rdata_r;
endmodule : fsr_host

// file: rtl/fsr_pkg.sv
// shared constants for the flash software reset sequencer
package fsr_pkg;
  // =====================================================
  // opcodes
  localparam logic [7:0] OP_ARM = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_QEN = 8'h38;
  localparam logic [7:0] OP_QEX = 8'hff;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_SERASE = 8'h20;
  // =====================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int T_RST_US = 30;
  localparam int RST_CYC = T_RST_US * CLK_MHZ;
  localparam int T_VSL_US = 20;
  localparam int VSL_CYC = T_VSL_US * CLK_MHZ;
  localparam int T_PUW_MS = 5;
  localparam int PUW_CYC = T_PUW_MS * 1000 * CLK_MHZ;
  localparam int T_CSH_NS = 50;
  localparam int CSH_CYC = (T_CSH_NS * CLK_MHZ + 999) / 1000;
  localparam int SCK_HALF = 2;
  localparam int TMR_W = 21;
  // =====================================================
  // device status byte layout and reset values
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_SUS = 2;
  localparam logic [7:0] VSTAT_RST = 8'h00;
  localparam logic [7:0] RPARM_RST = 8'h00;
  localparam logic [7:0] CMODE_RST = 8'h00;
  localparam logic [2:0] WRAP_RST = 3'h0;
  localparam logic [3:0] BITS_OP = 4'h8;
  localparam logic [3:0] BITS_OVER = 4'h9;
  // =====================================================
  // host register map and status layout
  localparam logic [3:0] HR_CMD = 4'h0;
  localparam logic [3:0] HR_RESET = 4'h1;
  localparam logic [3:0] HR_STATUS = 4'h2;
  localparam logic [3:0] HR_LAST = 4'h3;
  localparam int HS_BUSY = 0;
  localparam int HS_SEL_OK = 1;
  localparam int HS_WR_OK = 2;
  localparam int HS_REFUSED = 3;
  localparam int HS_QUAD = 4;
endpackage : fsr_pkg

// file: rtl/fsr_link_if.sv
// serial link between flash host controller and flash device
`timescale 1ns/1ps
interface fsr_link_if;
  logic cs_n;
  logic sck;
  logic [3:0] h_do;
  logic [3:0] h_oe;
  logic [3:0] d_do;
  logic [3:0] d_oe;
  logic [3:0] io;
  // undriven lines float high through the board pull-up
  assign io = (h_oe & h_do) | (~h_oe & d_oe & d_do) | (~h_oe & ~d_oe);
  modport host (output cs_n, output sck, output h_do, output h_oe,
                input io);
  modport dev (input cs_n, input sck, input io, output d_do,
               output d_oe);
endinterface : fsr_link_if

// file: rtl/fsr_timer.sv
// load-and-count-down wait timer
`timescale 1ns/1ps
module fsr_timer #(
  parameter int W = fsr_pkg::TMR_W
) (
  input wire logic clk_i, // clock
  input wire logic nrst_i, // sync reset, active low
  input wire logic start_i, // load pulse
  input wire logic [W-1:0] load_i, // cycles to stay busy
  output logic busy_o // count not yet expired
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
    end else if (start_i) begin
      cnt_r <= load_i;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign busy_o = (cnt_r != '0);
endmodule : fsr_timer

// file: rtl/fsr_dev.sv
// flash device end: opcode capture, reset arming and volatile state
`timescale 1ns/1ps
module fsr_dev #(
  parameter int RST_CYC = fsr_pkg::RST_CYC
) (
  input wire logic clk_i, // clock
  input wire logic nrst_i, // sync reset, active low
  fsr_link_if.dev link, // serial link
  input wire logic op_busy_i, // core operation running
  input wire logic susp_set_i, // core enters suspend
  input wire logic susp_clr_i, // core resumes
  input wire logic vstat_wr_i, // load volatile status bits
  input wire logic [7:0] vstat_i, // volatile status value
  input wire logic rparm_wr_i, // load read parameters
  input wire logic [7:0] rparm_i, // read parameter value
  input wire logic cmode_wr_i, // load continuous mode bits
  input wire logic [7:0] cmode_i, // continuous mode value
  input wire logic wrap_wr_i, // load wrap setting
  input wire logic [2:0] wrap_i, // wrap setting value
  output logic op_abort_o, // pulse: abort core operation
  output logic cmd_valid_o, // pulse: other opcode taken
  output logic [7:0] cmd_o, // opcode taken
  output logic rst_busy_o, // reset recovery running
  output logic armed_o, // reset is armed
  output logic quad_o, // quad command mode active
  output logic wel_o, // write_enable_latch_flag
  output logic susp_o, // suspend_flag
  output logic [7:0] vstat_o, // volatile status bits
  output logic [7:0] rparm_o, // read_parameter_bits
  output logic [7:0] cmode_o, // continuous_mode_bits
  output logic [2:0] wrap_o // wrap_setting_bits
);
  // =====================================================
  // link edge detection
  logic sck_d_r;
  logic cs_d_r;
  logic rise;
  logic fall;
  logic fend;
  logic fbeg;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [3:0] nbits_r;
  logic exact;
  logic any_cmd;
  logic do_reset;
  logic rst_busy;
  logic armed_r;
  logic quad_r;
  logic wel_r;
  logic susp_r;
  logic rd_ph_r;
  logic oe_r;
  logic [7:0] dout_r;
  logic [3:0] io_r;
  logic [7:0] sbyte;
  logic abort_r;
  logic cmd_v_r;
  logic [7:0] cmd_r;
  logic [7:0] vstat_r;
  logic [7:0] rparm_r;
  logic [7:0] cmode_r;
  logic [2:0] wrap_r;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sck_d_r <= link.sck;
      cs_d_r <= link.cs_n;
    end
  end

  assign rise = link.sck & ~sck_d_r & ~link.cs_n;
  assign fall = ~link.sck & sck_d_r & ~link.cs_n;
  assign fend = link.cs_n & ~cs_d_r;
  assign fbeg = ~link.cs_n & cs_d_r;

  // =====================================================
  // opcode shifter; quad mode takes a nibble per clock
  always_comb begin
    sh_nxt = quad_r ? {sh_r[3:0], link.io} : {sh_r[6:0], link.io[0]};
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sh_r <= 8'h00;
      nbits_r <= 4'h0;
    end else if (fbeg) begin
      nbits_r <= 4'h0;
    end else if (rise) begin
      if (nbits_r < fsr_pkg::BITS_OP) begin
        sh_r <= sh_nxt;
        nbits_r <= nbits_r + (quad_r ? 4'h4 : 4'h1);
      end else begin
        // any clock past the opcode marks a longer frame
        nbits_r <= fsr_pkg::BITS_OVER;
      end
    end
  end

  // =====================================================
  // frame decode
  assign exact = fend && (nbits_r == fsr_pkg::BITS_OP) && !rst_busy;
  assign any_cmd = fend && (nbits_r != 4'h0) && !rst_busy;
  assign do_reset = exact && (sh_r == fsr_pkg::OP_RST) && armed_r;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      armed_r <= 1'b0;
    end else if (any_cmd) begin
      armed_r <= exact && (sh_r == fsr_pkg::OP_ARM);
    end
  end

  fsr_timer #(.W(fsr_pkg::TMR_W)) u_rst_tmr (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(do_reset),
    .load_i(fsr_pkg::TMR_W'(RST_CYC)),
    .busy_o(rst_busy)
  );

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      abort_r <= 1'b0;
    end else begin
      abort_r <= do_reset;
    end
  end

  // the arm and reset opcodes are not passed on to the core
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cmd_v_r <= 1'b0;
      cmd_r <= 8'h00;
    end else begin
      cmd_v_r <= exact && (sh_r != fsr_pkg::OP_ARM)
                 && (sh_r != fsr_pkg::OP_RST);
      if (exact) begin
        cmd_r <= sh_r;
      end
    end
  end

  // =====================================================
  // volatile state; an accepted reset wins over every load
  always_ff @(posedge clk_i) begin
    if (!nrst_i || do_reset) begin
      quad_r <= 1'b0;
    end else if (exact && sh_r == fsr_pkg::OP_QEN) begin
      quad_r <= 1'b1;
    end else if (exact && sh_r == fsr_pkg::OP_QEX) begin
      quad_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i || do_reset) begin
      wel_r <= 1'b0;
    end else if (exact && sh_r == fsr_pkg::OP_WREN) begin
      wel_r <= 1'b1;
    end else if (exact && sh_r == fsr_pkg::OP_WRDI) begin
      wel_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i || do_reset) begin
      susp_r <= 1'b0;
    end else if (susp_set_i) begin
      susp_r <= 1'b1;
    end else if (susp_clr_i) begin
      susp_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i || do_reset) begin
      vstat_r <= fsr_pkg::VSTAT_RST;
    end else if (vstat_wr_i) begin
      vstat_r <= vstat_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i || do_reset) begin
      rparm_r <= fsr_pkg::RPARM_RST;
    end else if (rparm_wr_i) begin
      rparm_r <= rparm_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i || do_reset) begin
      cmode_r <= fsr_pkg::CMODE_RST;
    end else if (cmode_wr_i) begin
      cmode_r <= cmode_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i || do_reset) begin
      wrap_r <= fsr_pkg::WRAP_RST;
    end else if (wrap_wr_i) begin
      wrap_r <= wrap_i;
    end
  end

  // =====================================================
  // status read: byte repeats while the host keeps clocking
  always_comb begin
    sbyte = 8'h00;
    sbyte[fsr_pkg::ST_BUSY] = op_busy_i | rst_busy;
    sbyte[fsr_pkg::ST_WEL] = wel_r;
    sbyte[fsr_pkg::ST_SUS] = susp_r;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i || fend) begin
      rd_ph_r <= 1'b0;
      oe_r <= 1'b0;
      dout_r <= 8'h00;
      io_r <= 4'h0;
    end else if (rise && !rd_ph_r && !rst_busy
                 && nbits_r + (quad_r ? 4'h4 : 4'h1) == fsr_pkg::BITS_OP
                 && sh_nxt == fsr_pkg::OP_RDSR) begin
      rd_ph_r <= 1'b1;
      dout_r <= sbyte;
    end else if (fall && rd_ph_r) begin
      oe_r <= 1'b1;
      if (quad_r) begin
        io_r <= dout_r[7:4];
        dout_r <= {dout_r[3:0], dout_r[7:4]};
      end else begin
        io_r <= {2'b00, dout_r[7], 1'b0};
        dout_r <= {dout_r[6:0], dout_r[7]};
      end
    end
  end

  assign link.d_do = io_r;
  assign link.d_oe = oe_r ? (quad_r ? 4'hf : 4'h2) : 4'h0;

  assign op_abort_o = abort_r;
  assign cmd_valid_o = cmd_v_r;
  assign cmd_o = cmd_r;
  assign rst_busy_o = rst_busy;
  assign armed_o = armed_r;
  assign quad_o = quad_r;
  assign wel_o = wel_r;
  assign susp_o = susp_r;
  assign vstat_o = vstat_r;
  assign rparm_o = rparm_r;
  assign cmode_o = cmode_r;
  assign wrap_o = wrap_r;
endmodule : fsr_dev

// file: dv/fsr_link_checker.sv
// assertions on the serial link and the device reset state
`timescale 1ns/1ps
module fsr_link_checker #(
  parameter int RST_CYC = 30
) (
  input wire logic clk_i, // clock
  input wire logic nrst_i, // sync reset, active low
  input wire logic cs_n, // frame select
  input wire logic sck, // serial clock
  input wire logic [3:0] d_oe, // device enables
  input wire logic op_abort_o, // abort pulse
  input wire logic cmd_valid_o, // opcode taken
  input wire logic rst_busy_o, // recovery running
  input wire logic armed_o, // reset armed
  input wire logic quad_o, // quad mode
  input wire logic wel_o, // latch flag
  input wire logic susp_o, // suspend flag
  input wire logic [7:0] vstat_o, // volatile bits
  input wire logic [7:0] rparm_o, // read parameters
  input wire logic [7:0] cmode_o, // continuous mode
  input wire logic [2:0] wrap_o // wrap setting
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  // =====================================================
  // length of the current recovery run
  int busy_cnt;
  always_ff @(posedge clk_i) begin
    if (!nrst_i)
      busy_cnt <= 0;
    else if (rst_busy_o)
      busy_cnt <= busy_cnt + 1;
    else
      busy_cnt <= 0;
  end
  // =====================================================
  // checks
  chk_abort_clears: assert property (op_abort_o |-> rst_busy_o && !wel_o
    && !susp_o && vstat_o == 0 && rparm_o == 0 && cmode_o == 0 && wrap_o == 0)
    else $error("volatile state kept after abort");
  chk_abort_pulse: assert property (op_abort_o |=> !op_abort_o)
    else $error("abort pulse too long");
  chk_needs_arm: assert property ($rose(rst_busy_o) |-> $past(armed_o))
    else $error("reset without arming");
  chk_reset_serial: assert property ($rose(rst_busy_o) |-> !quad_o)
    else $error("quad mode kept after reset");
  chk_busy_quiet: assert property (rst_busy_o |-> !cmd_valid_o && !armed_o)
    else $error("command taken in recovery");
  chk_recover_len: assert property ($fell(rst_busy_o) |-> busy_cnt >= RST_CYC)
    else $error("recovery too short");
  chk_other_disarm: assert property (cmd_valid_o |=> !armed_o)
    else $error("armed after other opcode");
  chk_sck_idle: assert property (cs_n |-> !sck)
    else $error("clock outside frame");
  chk_dev_release: assert property (cs_n && $past(cs_n) |-> d_oe == 4'h0)
    else $error("device drives outside frame");
endmodule : fsr_link_checker

// file: dv/tb.sv
// testbench: host and device ends joined by the link
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin \
  err_total++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb;
  logic clk_i = 0;
  logic nrst_i = 0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o, v, cmd_o, vstat_o, rparm_o, cmode_o;
  logic wr_i = 0, rd_i = 0, op_busy_i = 0, susp_set_i = 0, vload = 0;
  logic susp_clr_i = 0;
  logic [7:0] vstat_i = 8'h5a, rparm_i = 8'h3c, cmode_i = 8'hc3;
  logic [2:0] wrap_i = 3'h5;
  logic [2:0] wrap_o;
  logic op_abort_o, cmd_valid_o, rst_busy_o, armed_o, quad_o, wel_o, susp_o;
  int err_total = 0, checked = 0, n_abort = 0, k;
  logic [9:0] rows [4] = '{{8'h38, 2'b10}, {8'hff, 2'b00},
    {8'h04, 2'b00}, {8'h06, 2'b01}};
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (op_abort_o === 1'b1) n_abort++;
  fsr_link_if link();
  fsr_host #(.VSL_CYC(20), .PUW_CYC(200), .RST_CYC(30))
    fsr_host_i (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .link(link));
  fsr_dev #(.RST_CYC(30)) fsr_dev_i (.clk_i, .nrst_i, .link(link),
    .op_busy_i, .susp_set_i, .susp_clr_i, .vstat_wr_i(vload),
    .vstat_i, .rparm_wr_i(vload), .rparm_i,
    .cmode_wr_i(vload), .cmode_i, .wrap_wr_i(vload),
    .wrap_i, .op_abort_o, .cmd_valid_o, .cmd_o, .rst_busy_o,
    .armed_o, .quad_o, .wel_o, .susp_o, .vstat_o, .rparm_o, .cmode_o,
    .wrap_o);
  fsr_link_checker #(.RST_CYC(30)) fsr_link_checker_i (.clk_i, .nrst_i,
    .cs_n(link.cs_n), .sck(link.sck), .d_oe(link.d_oe), .op_abort_o,
    .cmd_valid_o, .rst_busy_o, .armed_o, .quad_o, .wel_o, .susp_o,
    .vstat_o, .rparm_o, .cmode_o, .wrap_o);
  // =====================================================
  // register bus tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  // poll until status bit b equals e, bounded
  task automatic wait_bit(input int b, input logic e);
    for (k = 0; k < 3000; k++) begin
      rd(fsr_pkg::HR_STATUS);
      if (v[b] === e) break;
    end
    if (k == 3000) begin
      err_total++;
      $display("[ERR] status bit %0d stuck", b);
    end
  endtask : wait_bit
  task automatic send(input logic [3:0] a, input logic [7:0] d);
    wr(a, d);
    repeat (2) @(posedge clk_i);
    wait_bit(fsr_pkg::HS_BUSY, 1'b0);
  endtask : send
  task automatic stop_test;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    #80000;
    err_total++;
    $display("[ERR] watchdog expired");
    stop_test();
  end
  // =====================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(fsr_pkg::HR_STATUS);
    `CHK("sel_ok early", 1'b0, v[fsr_pkg::HS_SEL_OK])
    wait_bit(fsr_pkg::HS_SEL_OK, 1'b1);
    send(fsr_pkg::HR_CMD, fsr_pkg::OP_WREN);
    rd(fsr_pkg::HR_STATUS);
    `CHK("early write", 1'b1, v[fsr_pkg::HS_REFUSED])
    `CHK("wel early", 1'b0, wel_o)
    wr(fsr_pkg::HR_STATUS, 8'h08);
    wait_bit(fsr_pkg::HS_WR_OK, 1'b1);
    for (int i = 0; i < 4; i++) begin
      send(fsr_pkg::HR_CMD, rows[i][9:2]);
      `CHK("cmd", rows[i][9:2], cmd_o)
      `CHK("quad", rows[i][1], quad_o)
      `CHK("wel", rows[i][0], wel_o)
    end
    // an interposed opcode must spoil the pair
    send(fsr_pkg::HR_CMD, fsr_pkg::OP_ARM);
    `CHK("armed", 1'b1, armed_o)
    send(fsr_pkg::HR_CMD, fsr_pkg::OP_WRDI);
    `CHK("disarmed", 1'b0, armed_o)
    send(fsr_pkg::HR_CMD, fsr_pkg::OP_RST);
    `CHK("lone reset", 0, n_abort)
    send(fsr_pkg::HR_CMD, fsr_pkg::OP_QEN);
    send(fsr_pkg::HR_CMD, fsr_pkg::OP_WREN);
    @(posedge clk_i);
    vload <= 1'b1;
    susp_set_i <= 1'b1;
    susp_clr_i <= 1'b1;
    op_busy_i <= 1'b1;
    @(posedge clk_i);
    vload <= 1'b0;
    susp_set_i <= 1'b0;
    susp_clr_i <= 1'b0;
    @(posedge clk_i);
    `CHK("loaded", 8'h5a, vstat_o)
    `CHK("loaded rest", {8'h3c, 8'hc3, 3'h5}, {rparm_o, cmode_o, wrap_o})
    `CHK("susp set wins", 1'b1, susp_o)
    send(fsr_pkg::HR_RESET, 8'h01);
    rd(fsr_pkg::HR_STATUS);
    `CHK("safe refusal", 1'b1, v[fsr_pkg::HS_REFUSED])
    `CHK("safe abort", 0, n_abort)
    wr(fsr_pkg::HR_STATUS, 8'h08);
    send(fsr_pkg::HR_RESET, 8'h00);
    `CHK("abort", 1, n_abort)
    `CHK("flags", 3'b000, {wel_o, susp_o, quad_o})
    `CHK("settings", 27'h0, {vstat_o, rparm_o, cmode_o, wrap_o})
    `CHK("recovered", 1'b0, rst_busy_o)
    // the aborted core operation has ended, so status shows no busy
    @(posedge clk_i);
    op_busy_i <= 1'b0;
    send(fsr_pkg::HR_CMD, fsr_pkg::OP_WREN);
    send(fsr_pkg::HR_CMD, fsr_pkg::OP_RDSR);
    rd(fsr_pkg::HR_LAST);
    `CHK("status byte", 8'h02, v)
    rd(4'h9);
    `CHK("unmapped", 8'h00, v)
    stop_test();
  end
endmodule : tb
